// >>> hw/ptt_map.vh
// Functional notes
// RULE1: Tick counter runs from the internal RC clock when select is 0, else oscillator.
// RULE2: In stop mode the tick counts only in pseudo-stop with oscillator clock selected.
// RULE3: Tick rate control register is readable and writable at any time.
// RULE4: Every write to the tick rate control register restarts the divider chain.
// RULE5: Changing the clock select or losing oscillator-up status restarts the period.
// RULE6: Bit 7 selects the binary (0) or decimal (1) prescaler ladder.
// RULE7: Bits 6 to 4 pick one of eight prescaler values from the active ladder.
// RULE8: Bits 3 to 0 give a modulus divide of the field value plus one.
// RULE9: Binary codes 001 to 111 divide by two to the powers 10 to 16.
// RULE10: Binary code 000 turns the tick off and is the reset default.
// RULE11: Decimal codes divide by 1000 up to 200000; none turns the tick off.
// RULE12: Clock select takes a 1 only while oscillator is up; cleared when it drops.
// RULE13: Pseudo-stop running needs the stop-enable bit; a static counter keeps its value.
// RULE14: Each completed period raises a tick flag and starts the next period at once.
`ifndef PTT_MAP_VH
`define PTT_MAP_VH

// Register indices; byte address is four times the index
`define PTT_IDX_RATE        4'hB
`define PTT_IDX_STATUS      4'hC
`define PTT_IDX_MASK        4'hD
`define PTT_IDX_CTRL        4'hE
`define PTT_IDX_COUNT       4'hF

// tick_rate_control fields
`define PTT_RATE_DEC_BIT    7
`define PTT_RATE_PRE_HI     6
`define PTT_RATE_PRE_LO     4
`define PTT_RATE_MOD_HI     3
`define PTT_RATE_MOD_LO     0
`define PTT_RATE_RESET      8'h00

// tick_stop_control fields
`define PTT_CTRL_CLKSEL_BIT 0
`define PTT_CTRL_STOPEN_BIT 1
`define PTT_CTRL_PSTOP_BIT  2
`define PTT_CTRL_RESET      3'h0

// Status and mask fields
`define PTT_ST_TICK_BIT     0
`define PTT_ST_OSCLOSS_BIT  1
`define PTT_ST_RESET        2'h0

// Prescaler steps
`define PTT_BIN_BASE_EXP    10
`define PTT_DEC_STEP0       18'h003E8
`define PTT_DEC_STEP1       18'h007D0
`define PTT_DEC_STEP2       18'h01388
`define PTT_DEC_STEP3       18'h02710
`define PTT_DEC_STEP4       18'h04E20
`define PTT_DEC_STEP5       18'h0C350
`define PTT_DEC_STEP6       18'h186A0
`define PTT_DEC_STEP7       18'h30D40
`define PTT_PRE_OFF         18'h00000

`endif

// >>> hw/ptt_timer.v
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "ptt_map.vh"

module ptt_timer #(
   parameter PRE_W = 18,
   parameter MOD_W = 4
) (
   input  wire        clock,
   input  wire        rst,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [5:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        internal_rc_clock,
   input  wire        external_osc_clock,
   input  wire        oscillator_up_status,
   input  wire        stop_mode,
   output reg         periodic_tick,
   output reg         irq
);

   // Prescaler value for a ladder and code; zero means the tick is off
   function [PRE_W-1:0] ptt_prescale;
      input       dec;
      input [2:0] code;
      begin
         if (dec) begin
            case (code) // [RULE11]
               3'h0:    ptt_prescale = `PTT_DEC_STEP0;
               3'h1:    ptt_prescale = `PTT_DEC_STEP1;
               3'h2:    ptt_prescale = `PTT_DEC_STEP2;
               3'h3:    ptt_prescale = `PTT_DEC_STEP3;
               3'h4:    ptt_prescale = `PTT_DEC_STEP4;
               3'h5:    ptt_prescale = `PTT_DEC_STEP5;
               3'h6:    ptt_prescale = `PTT_DEC_STEP6;
               3'h7:    ptt_prescale = `PTT_DEC_STEP7;
               default: ptt_prescale = `PTT_PRE_OFF;
            endcase
         end else if (code == 3'h0) begin
            ptt_prescale = `PTT_PRE_OFF; // [RULE10]
         end else begin
            ptt_prescale = {{(PRE_W-1){1'b0}}, 1'b1}
                           << (`PTT_BIN_BASE_EXP - 1 + code); // [RULE9]
         end
      end
   endfunction

   // Register index from a byte address
   function [3:0] ptt_index;
      input [5:0] adr;
      begin
         ptt_index = adr[5:2];
      end
   endfunction

   reg  [7:0]       tick_rate_control;
   reg              tick_clock_select;
   reg              stop_enable;
   reg              pseudo_stop_select;
   reg  [1:0]       tick_status;
   reg  [1:0]       tick_mask;
   reg  [PRE_W-1:0] pre_count;
   reg  [MOD_W-1:0] mod_count;
   reg              irc_prev;
   reg              osc_prev;
   reg              osc_up_prev;
   reg  [31:0]      next_dat_o;
   reg  [1:0]       next_tick_status;

   wire             decimal_ladder_select;
   wire [2:0]       prescale_code;
   wire [MOD_W-1:0] modulus_code;
   wire [PRE_W-1:0] pre_target;
   wire             bus_req;
   wire             bus_wr;
   wire [3:0]       bus_idx;
   wire             rate_write;
   wire             ctrl_write;
   wire             next_clock_select;
   wire             clock_select_change;
   wire             osc_lost;
   wire             restart;
   wire             ref_sel;
   wire             ref_edge;
   wire             stop_allows;
   wire             running;
   wire             pre_wrap;
   wire             mod_wrap;
   wire             tick_event;
   wire             status_write;
   wire             mask_write;
   wire             irc_edge;
   wire             osc_edge;
   wire             irq_level;
   wire [31:0]      count_word;

   assign decimal_ladder_select = tick_rate_control[`PTT_RATE_DEC_BIT]; // [RULE6]
   assign prescale_code = tick_rate_control[`PTT_RATE_PRE_HI:`PTT_RATE_PRE_LO]; // [RULE7]
   assign modulus_code  = tick_rate_control[`PTT_RATE_MOD_HI:`PTT_RATE_MOD_LO]; // [RULE8]
   assign pre_target    = ptt_prescale(decimal_ladder_select, prescale_code);

   // Single-cycle classic slave: one wait state, ack dropped after one cycle
   assign bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr     = bus_req & wb_we_i & wb_sel_i[0];
   assign bus_idx    = ptt_index(wb_adr_i);
   assign rate_write = bus_wr & (bus_idx == `PTT_IDX_RATE); // [RULE3]
   assign ctrl_write = bus_wr & (bus_idx == `PTT_IDX_CTRL);
   // Writes need byte lane 0; every writable register bit lives in the low byte
   assign status_write = bus_wr & (bus_idx == `PTT_IDX_STATUS);
   assign mask_write   = bus_wr & (bus_idx == `PTT_IDX_MASK);

   // Select accepts a 1 only with the oscillator up
   assign next_clock_select = wb_dat_i[`PTT_CTRL_CLKSEL_BIT] & oscillator_up_status; // [RULE12]
   assign clock_select_change = ctrl_write & (next_clock_select != tick_clock_select);
   assign osc_lost = osc_up_prev & ~oscillator_up_status;

   // A reference edge in the restart cycle is dropped so the new period starts clean
   assign restart = rate_write | clock_select_change | osc_lost; // [RULE4] [RULE5]

   // Reference edge taken from the selected source
   assign ref_sel  = tick_clock_select ? external_osc_clock : internal_rc_clock; // [RULE1]
   // Pins must run below half the clock, or edges are lost
   assign irc_edge = internal_rc_clock & ~irc_prev;
   assign osc_edge = external_osc_clock & ~osc_prev;
   assign ref_edge = tick_clock_select ? osc_edge : irc_edge; // [RULE1]

   // Stop mode freezes the chain unless pseudo-stop with oscillator and enable
   assign stop_allows = ~stop_mode |
                        (pseudo_stop_select & tick_clock_select & stop_enable); // [RULE2] [RULE13]
   // Prescale code off freezes the chain at zero, where the rate write that set the code left it
   assign running  = (pre_target != `PTT_PRE_OFF) & stop_allows;
   assign pre_wrap = (pre_count == pre_target - {{(PRE_W-1){1'b0}}, 1'b1});
   assign mod_wrap = (mod_count == modulus_code);
   assign tick_event = running & ref_edge & pre_wrap & mod_wrap & ~restart;

   // Pin history for rising-edge detection; pins are taken as synchronous
   always @(posedge clock) begin
      if (rst) begin
         irc_prev <= 1'b0;
      end else begin
         irc_prev <= internal_rc_clock;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= external_osc_clock;
      end
   end

   // Oscillator status history; a falling level marks a loss
   always @(posedge clock) begin
      if (rst) begin
         osc_up_prev <= 1'b0;
      end else begin
         osc_up_prev <= oscillator_up_status;
      end
   end

   // Rate register: any write restarts the period through restart
   always @(posedge clock) begin
      if (rst) begin
         tick_rate_control <= `PTT_RATE_RESET; // [RULE10]
      end else if (rate_write) begin
         tick_rate_control <= wb_dat_i[7:0]; // [RULE3]
      end
   end

   // Clock select: a 1 sticks only while the oscillator is up
   // Loss of the oscillator wins over a write in the same cycle
   always @(posedge clock) begin
      if (rst) begin
         tick_clock_select <= 1'b0;
      end else if (~oscillator_up_status) begin
         tick_clock_select <= 1'b0; // [RULE12]
      end else if (ctrl_write) begin
         tick_clock_select <= next_clock_select; // [RULE12]
      end
   end

   // Stop behaviour bits; both and the oscillator select let the tick run in pseudo-stop
   always @(posedge clock) begin
      if (rst) begin
         stop_enable        <= 1'b0;
         pseudo_stop_select <= 1'b0;
      end else if (ctrl_write) begin
         stop_enable        <= wb_dat_i[`PTT_CTRL_STOPEN_BIT];
         pseudo_stop_select <= wb_dat_i[`PTT_CTRL_PSTOP_BIT];
      end
   end

   // Interrupt mask, same layout as status
   always @(posedge clock) begin
      if (rst) begin
         tick_mask <= `PTT_ST_RESET;
      end else if (mask_write) begin
         tick_mask <= wb_dat_i[1:0];
      end
   end

   // Prescaler: counts reference edges up to its target
   always @(posedge clock) begin
      if (rst) begin
         pre_count <= {PRE_W{1'b0}};
      end else if (restart) begin
         pre_count <= {PRE_W{1'b0}}; // [RULE4] [RULE5]
      end else if (running & ref_edge) begin
         if (pre_wrap) begin
            pre_count <= {PRE_W{1'b0}}; // [RULE9] [RULE11]
         end else begin
            pre_count <= pre_count + {{(PRE_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Modulus counter: steps once per prescaler wrap; a halted chain keeps its count
   always @(posedge clock) begin
      if (rst) begin
         mod_count <= {MOD_W{1'b0}};
      end else if (restart) begin
         mod_count <= {MOD_W{1'b0}};
      end else if (running & ref_edge & pre_wrap) begin
         if (mod_wrap) begin
            mod_count <= {MOD_W{1'b0}}; // [RULE14]
         end else begin
            mod_count <= mod_count + {{(MOD_W-1){1'b0}}, 1'b1}; // [RULE8]
         end
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear
   // Oscillator loss is reported too, since it restarts the period
   always @* begin
      next_tick_status = tick_status;
      if (status_write) begin
         next_tick_status = tick_status & ~wb_dat_i[1:0];
      end
      if (tick_event) begin
         next_tick_status[`PTT_ST_TICK_BIT] = 1'b1; // [RULE14]
      end
      if (osc_lost) begin
         next_tick_status[`PTT_ST_OSCLOSS_BIT] = 1'b1;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         tick_status <= `PTT_ST_RESET;
      end else begin
         tick_status <= next_tick_status;
      end
   end

   assign irq_level = |(tick_status & tick_mask);

   // Tick pulse, one cycle after the last reference edge of a period
   always @(posedge clock) begin
      if (rst) begin
         periodic_tick <= 1'b0;
      end else begin
         periodic_tick <= tick_event; // [RULE14]
      end
   end

   // Level interrupt while an unmasked status bit is set
   always @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_level;
      end
   end

   // Count word: prescale count, modulus count, running flag, selected pin level
   assign count_word = {{(32-PRE_W-MOD_W-2){1'b0}}, ref_sel, running, mod_count, pre_count};

   // Read data for the addressed register; reads have no side effects
   always @* begin
      case (bus_idx)
         `PTT_IDX_RATE:   next_dat_o = {24'h000000, tick_rate_control}; // [RULE3]
         `PTT_IDX_STATUS: next_dat_o = {30'h00000000, tick_status};
         `PTT_IDX_MASK:   next_dat_o = {30'h00000000, tick_mask};
         `PTT_IDX_CTRL:   next_dat_o = {29'h00000000, pseudo_stop_select,
                                        stop_enable, tick_clock_select};
         `PTT_IDX_COUNT:  next_dat_o = count_word;
         default:         next_dat_o = 32'h00000000;
      endcase
   end

   // Bus answer, registered
   always @(posedge clock) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            wb_dat_o <= next_dat_o;
         end
      end
   end

endmodule

// >>> test/ptt_timer_monitor.sv
`timescale 1ns/1ps
module ptt_timer_monitor (
   input wire        clock,
   input wire        rst,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [5:0]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        internal_rc_clock,
   input wire        external_osc_clock,
   input wire        oscillator_up_status,
   input wire        stop_mode,
   input wire        periodic_tick,
   input wire        irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rate_wr;
      s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] == 4'hB);
   endsequence
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_answer: assert property (s_take |=> wb_ack_o)
      else $error("request not acked");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_data_width: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h00)
      else $error("read data upper byte set");
   // A restarted period needs at least 1000 reference edges, so no tick can follow soon
   a_rate_restart: assert property (s_rate_wr |=> ##1 !periodic_tick [*7])
      else $error("tick right after rate write");
   a_tick_pulse: assert property (periodic_tick |=> !periodic_tick)
      else $error("tick longer than one cycle");
   a_irq_sticky: assert property ($fell(irq) |->
      $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
      else $error("irq dropped without write");
   a_stop_halt: assert property (periodic_tick |->
      !$past(stop_mode) || $past(oscillator_up_status))
      else $error("tick in stop without oscillator");
endmodule
bind ptt_timer ptt_timer_monitor u_mon (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .internal_rc_clock(internal_rc_clock), .external_osc_clock(external_osc_clock),
   .oscillator_up_status(oscillator_up_status), .stop_mode(stop_mode),
   .periodic_tick(periodic_tick), .irq(irq));

// >>> test/periodic_tick_timer_test.sv
`timescale 1ns/1ps
module periodic_tick_timer_test;
   reg         clock = 0, rst = 1, cyc = 0, stb = 0, we = 0, rc = 0, osc = 0, up = 0, stop = 0;
   reg  [5:0]  adr = 6'h00;
   reg  [3:0]  sel = 4'h0;
   reg  [31:0] wdat = 32'h0, rd;
   wire [31:0] dat_o;
   wire        ack, tick, irq;
   integer     error_cnt = 0, check_count = 0, tcnt = 0;
   always #12.5 clock = ~clock;
   always @(posedge clock) if (tick === 1'b1) tcnt <= tcnt + 1;
   ptt_timer dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .internal_rc_clock(rc), .external_osc_clock(osc), .oscillator_up_status(up),
      .stop_mode(stop), .periodic_tick(tick), .irq(irq));
   task check(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task bus(input w, input [5:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         cyc <= 1;
         stb <= 1;
         we <= w;
         adr <= a;
         wdat <= d;
         sel <= 4'hF;
         do begin
            @(posedge clock);
            n = n + 1;
         end while (ack !== 1'b1 && n < 20);
         if (n >= 20) check(0, 1);
         rd = dat_o;
         cyc <= 0;
         stb <= 0;
         we <= 0;
         @(posedge clock);
      end
   endtask
   // Pin high one clock, low two, then count the ticks seen
   task tk(input pin, input integer n, input integer exp);
      begin
         repeat (n) begin
            if (pin) osc <= 1;
            else rc <= 1;
            @(posedge clock);
            osc <= 0;
            rc <= 0;
            repeat (2) @(posedge clock);
         end
         repeat (4) @(posedge clock);
         check(tcnt, exp);
      end
   endtask
   task results;
      begin
         $display("checks %0d errors %0d", check_count, error_cnt);
         if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (90000) @(posedge clock);
      error_cnt = error_cnt + 1;
      results;
   end
   initial begin
      repeat (3) @(posedge clock);
      rst <= 0;
      @(posedge clock);
      bus(0, 6'h2C, 32'h0);
      check(rd, 32'h0);
      bus(1, 6'h00, 32'hFF);
      bus(0, 6'h00, 32'h0);
      check(rd, 32'h0);
      bus(1, 6'h34, 32'h1);
      bus(1, 6'h2C, 32'h10);
      bus(0, 6'h2C, 32'h0);
      check(rd, 32'h10);
      tk(0, 1023, 0);
      tk(0, 1, 1);
      check(irq, 1);
      bus(1, 6'h30, 32'h1);
      check(irq, 0);
      tk(0, 1024, 2);
      $display("binary ladder test done");
      tk(0, 600, 2);
      bus(1, 6'h2C, 32'h10);
      tk(0, 1023, 2);
      tk(0, 1, 3);
      bus(1, 6'h2C, 32'h11);
      tk(0, 2047, 3);
      tk(0, 1, 4);
      bus(1, 6'h2C, 32'h80);
      tk(0, 999, 4);
      tk(0, 1, 5);
      bus(1, 6'h2C, 32'h0F);
      tk(0, 2000, 5);
      $display("divide test done");
      bus(1, 6'h38, 32'h1);
      bus(0, 6'h38, 32'h0);
      check(rd, 32'h0);
      up <= 1;
      bus(1, 6'h38, 32'h1);
      bus(1, 6'h2C, 32'h10);
      tk(0, 1024, 5);
      tk(1, 1024, 6);
      up <= 0;
      repeat (2) @(posedge clock);
      bus(0, 6'h38, 32'h0);
      check(rd, 32'h0);
      bus(0, 6'h30, 32'h0);
      check(rd, 32'h3);
      $display("clock select test done");
      bus(1, 6'h2C, 32'h10);
      tk(0, 500, 6);
      stop <= 1;
      tk(0, 1024, 6);
      bus(0, 6'h3C, 32'h0);
      check(rd, 32'h000001F4);
      stop <= 0;
      tk(0, 523, 6);
      tk(0, 1, 7);
      up <= 1;
      bus(1, 6'h38, 32'h7);
      bus(1, 6'h2C, 32'h10);
      stop <= 1;
      tk(1, 1024, 8);
      stop <= 0;
      $display("stop test done");
      results;
   end
endmodule
